// File: inc/acctl_pkg.sv
// package of constants for the conversion control and overtemp flag block
// assumes a 125 MHz system clock on MCLK
package acctl_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned T_CONV_VOLT_US = 9;
  localparam int unsigned T_CONV_TEMP_US = 27;
  localparam int unsigned T_PWRUP_US = 2;
  localparam int unsigned T_FLAG_NS = 150;
  // only the flag time rounds down
  localparam int unsigned CYC_CONV_VOLT = T_CONV_VOLT_US * CLK_MHZ;
  localparam int unsigned CYC_CONV_TEMP = T_CONV_TEMP_US * CLK_MHZ;
  localparam int unsigned CYC_PWRUP = T_PWRUP_US * CLK_MHZ;
  localparam int unsigned CYC_FLAG = (T_FLAG_NS * CLK_MHZ) / 1000;
  localparam int unsigned RES_BITS = 10;
  localparam int unsigned THR_BITS = 8;
  localparam int unsigned CH_BITS = 3;
  localparam logic [2:0] CH_TEMP = 3'h0;
  localparam int unsigned CNT_BITS = 16;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_DOWN = 4'h4,
    ST_WAKE = 4'h8
  } acctl_state_e;
endpackage

// File: verilog/acctl_top.sv
// conversion control, busy, power-down and overtemperature flag
// assumes pins arrive asynchronously; result and threshold come from the core
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - falling convert-start edge starts a 10-bit conversion, sampler goes to hold
// - sampler returns to tracking when the conversion completes
// - convert-start low at conversion end powers the device down
// - busy is high during every conversion, low once it finishes
// - channel 0 result above 8-bit threshold drives overtemp flag low
// - rising read/write select with chip select low releases the flag
// - serial port acts only while chip select is asserted
// - voltage channel conversions end within 9 us
// - temperature conversions end within 27 us
// - power-up takes up to 2 us after convert-start rises
// - flag falls within 150 ns of busy falling
module acctl_top #(
  parameter int unsigned CONV_VOLT_CYC = acctl_pkg::CYC_CONV_VOLT,
  parameter int unsigned CONV_TEMP_CYC = acctl_pkg::CYC_CONV_TEMP,
  parameter int unsigned PWRUP_CYC = acctl_pkg::CYC_PWRUP
) (
  input wire logic MCLK, // system clock
  input wire logic NRST, // async reset, active low
  input wire logic CONVERT_START_N, // convert-start pin
  input wire logic CS_N, // chip select pin
  input wire logic RD_WR, // read/write select pin
  input wire logic [2:0] CHANNEL, // selected channel
  input wire logic [9:0] RESULT, // conversion result from the core
  input wire logic [7:0] OVERTEMP_THRESHOLD, // threshold register
  output logic BUSY, // conversion in progress
  output logic TRACK_HOLD, // high while holding
  output logic POWER_DOWN, // analog core powered down
  output logic CONV_DONE, // one-cycle end of conversion
  output logic OVERTEMP_FLAG_N // overtemperature flag, active low
);
  // ==========================================================
  // pin synchronisers
  // one two-flop chain per pin; idle-high reset means a pin that is
  // low at release looks like a fresh start edge
  localparam int unsigned PIN_CNT = 3;
  logic [PIN_CNT-1:0] pin_raw;
  wire [PIN_CNT-1:0] pin_sync;
  logic cst, cs_n, rw, cst_fall, cst_rise, rw_rise;

  assign pin_raw = {RD_WR, CS_N, CONVERT_START_N};

  for (genvar i = 0; i < PIN_CNT; i++) begin : g_sync
    logic s1_ff, s2_ff, nxt_s1, nxt_s2;

    always_comb begin
      nxt_s1 = pin_raw[i];
      nxt_s2 = s1_ff;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
        s1_ff <= 1'h1;
        s2_ff <= 1'h1;
      end else begin
        s1_ff <= nxt_s1;
        s2_ff <= nxt_s2;
      end
    end

    assign pin_sync[i] = s2_ff;
  end

  assign cst = pin_sync[0];
  assign cs_n = pin_sync[1];
  assign rw = pin_sync[2];

  // ==========================================================
  // edge detectors on the synchronised pins
  logic cst_d_ff, rw_d_ff, nxt_cst_d, nxt_rw_d;

  always_comb begin
    nxt_cst_d = cst;
    nxt_rw_d = rw;
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cst_d_ff <= 1'h1;
      rw_d_ff <= 1'h1;
    end else begin
      cst_d_ff <= nxt_cst_d;
      rw_d_ff <= nxt_rw_d;
    end
  end

  assign cst_fall = cst_d_ff & ~cst;
  assign cst_rise = ~cst_d_ff & cst;
  assign rw_rise = ~rw_d_ff & rw & ~cs_n;

  // ==========================================================
  // conversion sequencer
  acctl_pkg::acctl_state_e st_ff, nxt_st;
  logic [acctl_pkg::CNT_BITS-1:0] cnt_ff, nxt_cnt;
  logic temp_ff, nxt_temp;
  logic done;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_temp = temp_ff;
    done = 1'b0;
    case (st_ff)
      acctl_pkg::ST_IDLE: begin
        if (cst_fall) begin
          nxt_st = acctl_pkg::ST_CONV;
          // channel kept so the limit check uses the started channel
          nxt_temp = (CHANNEL == acctl_pkg::CH_TEMP);
          nxt_cnt = (CHANNEL == acctl_pkg::CH_TEMP) ?
            acctl_pkg::CNT_BITS'(CONV_TEMP_CYC - 1) :
            acctl_pkg::CNT_BITS'(CONV_VOLT_CYC - 1);
        end
      end
      acctl_pkg::ST_CONV: begin
        // new start edges are not looked at here
        if (cnt_ff == '0) begin
          done = 1'b1;
          nxt_st = cst ? acctl_pkg::ST_IDLE : acctl_pkg::ST_DOWN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      acctl_pkg::ST_DOWN: begin
        // a pin held low keeps the core off
        if (cst_rise) begin
          nxt_st = acctl_pkg::ST_WAKE;
          nxt_cnt = acctl_pkg::CNT_BITS'(PWRUP_CYC - 1);
        end
      end
      acctl_pkg::ST_WAKE: begin
        if (cnt_ff == '0) begin
          nxt_st = acctl_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_st = acctl_pkg::ST_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= acctl_pkg::ST_IDLE;
      cnt_ff <= '0;
      temp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      temp_ff <= nxt_temp;
    end
  end

  // ==========================================================
  // status outputs, busy, hold and power-down registered from the next state, done from the end count
  logic busy_ff, th_ff, pd_ff, done_ff;
  logic nxt_busy, nxt_th, nxt_pd, nxt_done;

  always_comb begin
    nxt_busy = (nxt_st == acctl_pkg::ST_CONV);
    nxt_th = (nxt_st == acctl_pkg::ST_CONV);
    nxt_pd = (nxt_st == acctl_pkg::ST_DOWN) ||
      (nxt_st == acctl_pkg::ST_WAKE);
    // end pulse lines up with the busy fall
    nxt_done = done;
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      busy_ff <= 1'b0;
      th_ff <= 1'b0;
      pd_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      th_ff <= nxt_th;
      pd_ff <= nxt_pd;
      done_ff <= nxt_done;
    end
  end

  // ==========================================================
  // overtemperature flag
  // top bits of the result meet the threshold at equal weight
  logic flag_n_ff, nxt_flag_n;
  logic over;

  assign over = RESULT[acctl_pkg::RES_BITS-1:acctl_pkg::RES_BITS-
    acctl_pkg::THR_BITS] > OVERTEMP_THRESHOLD;

  always_comb begin
    nxt_flag_n = flag_n_ff;
    if (rw_rise) begin
      nxt_flag_n = 1'b1;
    end
    // set wins over a release in the same cycle so no alarm is lost
    if (done && temp_ff && over) begin
      nxt_flag_n = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      flag_n_ff <= 1'b1;
    end else begin
      flag_n_ff <= nxt_flag_n;
    end
  end

  // ==========================================================
  // port drives
  assign BUSY = busy_ff;
  assign TRACK_HOLD = th_ff;
  assign POWER_DOWN = pd_ff;
  assign CONV_DONE = done_ff;
  assign OVERTEMP_FLAG_N = flag_n_ff;
endmodule // acctl_top

`default_nettype wire

// File: sim/acctl_assertions.sv
// port checker for the conversion control block
// bound below into every acctl_top instance
`timescale 1ns/1ps
`default_nettype none
module acctl_chk #(
  parameter int unsigned CONV_VOLT_CYC = 8,
  parameter int unsigned CONV_TEMP_CYC = 16
) (
  input wire logic MCLK, // clock
  input wire logic NRST, // reset
  input wire logic CS_N, // select
  input wire logic RD_WR, // read select
  input wire logic [2:0] CHANNEL, // channel
  input wire logic [9:0] RESULT, // result
  input wire logic [7:0] OVERTEMP_THRESHOLD, // limit
  input wire logic BUSY, // busy
  input wire logic TRACK_HOLD, // hold
  input wire logic POWER_DOWN, // down
  input wire logic CONV_DONE, // done
  input wire logic OVERTEMP_FLAG_N // flag
);
  int unsigned n_ff;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // busy cycle count
  always_ff @(posedge MCLK or negedge NRST)
    if (!NRST) n_ff <= 0;
    else n_ff <= BUSY ? n_ff + 1 : 0;
  // ====
  // checks
  chk_hold_busy: assert property (TRACK_HOLD == BUSY)
    else $error("hold differs from busy");
  chk_busy_len: assert property ($fell(BUSY) |->
    n_ff == (CHANNEL == 3'h0 ? CONV_TEMP_CYC : CONV_VOLT_CYC))
    else $error("busy length wrong");
  chk_done_fall: assert property ($fell(BUSY) |-> CONV_DONE)
    else $error("done missing at busy fall");
  chk_done_one: assert property (CONV_DONE |=> !CONV_DONE)
    else $error("done longer than a cycle");
  chk_pd_end: assert property ($rose(POWER_DOWN) |-> CONV_DONE)
    else $error("power down off conversion end");
  chk_pd_busy: assert property (!(BUSY && POWER_DOWN))
    else $error("busy while powered down");
  chk_start_idle: assert property ($rose(BUSY) |-> !$past(POWER_DOWN))
    else $error("start while powered down");
  chk_flag_set: assert property ($fell(OVERTEMP_FLAG_N) |->
    CONV_DONE && CHANNEL == 3'h0 && RESULT[9:2] > OVERTEMP_THRESHOLD)
    else $error("flag set without cause");
  chk_flag_rel: assert property ($rose(OVERTEMP_FLAG_N) |->
    $past(RD_WR, 3) && !$past(RD_WR, 4) && !$past(CS_N, 3))
    else $error("flag released without read");
  cv_hot: cover property ($fell(OVERTEMP_FLAG_N));
  cv_pd: cover property ($rose(POWER_DOWN));
  cv_rel: cover property ($rose(OVERTEMP_FLAG_N));
endmodule // acctl_chk
bind acctl_top acctl_chk #(.CONV_VOLT_CYC(CONV_VOLT_CYC),
  .CONV_TEMP_CYC(CONV_TEMP_CYC)) acctl_chk_inst (.MCLK(MCLK), .NRST(NRST),
  .CS_N(CS_N), .RD_WR(RD_WR), .CHANNEL(CHANNEL), .RESULT(RESULT),
  .OVERTEMP_THRESHOLD(OVERTEMP_THRESHOLD), .BUSY(BUSY),
  .TRACK_HOLD(TRACK_HOLD), .POWER_DOWN(POWER_DOWN),
  .CONV_DONE(CONV_DONE), .OVERTEMP_FLAG_N(OVERTEMP_FLAG_N));
`default_nettype wire

// File: sim/acctl_host.sv
// host model driving convert start and serial read pins
// assumes it shares the block clock
`timescale 1ns/1ps
`default_nettype none
module acctl_host (
  input wire logic clk, // clock
  output logic conv_n, // convert start
  output logic cs_n, // chip select
  output logic rd_wr // read select
);
  initial {conv_n, cs_n, rd_wr} = 3'h6;
  task automatic pulse(input bit hold);
    @(posedge clk) conv_n <= 1'b0;
    repeat (2) @(posedge clk);
    if (!hold) conv_n <= 1'b1;
  endtask
  task automatic rel;
    @(posedge clk) conv_n <= 1'b1;
  endtask
  task automatic read(input bit sel);
    @(posedge clk) cs_n <= !sel;
    @(posedge clk) rd_wr <= 1'b1;
    @(posedge clk) rd_wr <= 1'b0;
    @(posedge clk) cs_n <= 1'b1;
  endtask
endmodule // acctl_host
`default_nettype wire

// File: sim/acctl_top_tb.sv
// testbench for the conversion control block
// assumes small conversion counts 8, 16 and wake 4
`timescale 1ns/1ps
`default_nettype none
module acctl_top_tb;
  localparam int unsigned VOLT_CYC = 8;
  localparam int unsigned TEMP_CYC = 16;
  localparam int unsigned WAKE_CYC = 4;
  logic clk = 0, nrst = 0, busy, th, pd, done, flag_n, conv_n, cs_n, rd_wr;
  logic [2:0] ch = 3'h1;
  logic [9:0] res = 10'h000;
  logic [7:0] thr = 8'h80;
  int error_cnt = 0, cmp_count = 0;
  initial forever #4 clk = ~clk;
  acctl_top #(.CONV_VOLT_CYC(VOLT_CYC), .CONV_TEMP_CYC(TEMP_CYC),
    .PWRUP_CYC(WAKE_CYC)) acctl_top_inst (.MCLK(clk), .NRST(nrst),
    .CONVERT_START_N(conv_n), .CS_N(cs_n), .RD_WR(rd_wr), .CHANNEL(ch),
    .RESULT(res), .OVERTEMP_THRESHOLD(thr), .BUSY(busy), .TRACK_HOLD(th),
    .POWER_DOWN(pd), .CONV_DONE(done), .OVERTEMP_FLAG_N(flag_n));
  acctl_host acctl_host_inst (.clk(clk), .conv_n(conv_n), .cs_n(cs_n),
    .rd_wr(rd_wr));
  task automatic finish_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // one conversion, judged when busy falls
  task automatic conv(input logic [2:0] c, input logic [9:0] r,
                      input logic [7:0] t, input bit hold,
                      input logic [7:0] len, input logic f);
    int n = 0;
    @(posedge clk) begin ch <= c; res <= r; thr <= t; end
    fork acctl_host_inst.pulse(hold); join_none
    do @(negedge clk) n++; while (!busy && n < 9);
    if (!busy) begin error_cnt++; finish_test(); end
    if (!hold) fork acctl_host_inst.pulse(1'b0); join_none
    n = 0;
    while (busy && n < 40) begin @(negedge clk); n++; end
    if (n == 40) begin error_cnt++; finish_test(); end
    chk("busy cycles", len, 8'(n));
    chk("done", 8'h1, {7'h0, done});
    chk("hold", 8'h0, {7'h0, th});
    chk("flag", {7'h0, f}, {7'h0, flag_n});
    chk("power down", {7'h0, hold}, {7'h0, pd});
    repeat (4) @(negedge clk);
  endtask
  task automatic sc_volt;
    conv(3'h4, 10'h3ff, 8'h80, 1'b0, 8'(VOLT_CYC), 1'b1);
  endtask
  task automatic sc_hot;
    conv(3'h0, 10'h204, 8'h80, 1'b0, 8'(TEMP_CYC), 1'b0);
  endtask
  task automatic sc_edge;
    conv(3'h0, 10'h100, 8'h40, 1'b0, 8'(TEMP_CYC), 1'b1);
    conv(3'h0, 10'h104, 8'h40, 1'b0, 8'(TEMP_CYC), 1'b0);
  endtask
  task automatic sc_read;
    acctl_host_inst.read(1'b0);
    repeat (4) @(negedge clk);
    chk("flag kept", 8'h0, {7'h0, flag_n});
    acctl_host_inst.read(1'b1);
    repeat (4) @(negedge clk);
    chk("flag cleared", 8'h1, {7'h0, flag_n});
  endtask
  task automatic sc_pd;
    int n = 0;
    conv(3'h2, 10'h000, 8'h80, 1'b1, 8'(VOLT_CYC), 1'b0);
    acctl_host_inst.rel();
    while (pd && n < 20) begin @(negedge clk); n++; end
    chk("woken", 8'h0, {7'h0, pd});
    // two sync edges, the take edge, the wake count, first negedge
    chk("wake cycles", 8'(WAKE_CYC + 4), 8'(n));
    conv(3'h1, 10'h000, 8'h80, 1'b0, 8'(VOLT_CYC), 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    sc_volt();
    sc_hot();
    sc_read();
    sc_edge();
    sc_pd();
    finish_test();
  end
endmodule // acctl_top_tb
`default_nettype wire
